// [rtl/ext_query_pkg.sv]
// Purpose: shared constants for the extended query table responder
// Assumes: one 32-bit register word per query location
// Notes: query location n sits at byte address 4*n
package ext_query_pkg;

    // query location indices
    localparam logic [7:0] PTR_LO_IDX = 8'h15;
    localparam logic [7:0] PTR_HI_IDX = 8'h16;
    localparam logic [7:0] SIG0_IDX = 8'h35;
    localparam logic [7:0] SIG1_IDX = 8'h36;
    localparam logic [7:0] SIG2_IDX = 8'h37;
    localparam logic [7:0] MAJOR_IDX = 8'h38;
    localparam logic [7:0] MINOR_IDX = 8'h39;
    localparam logic [7:0] FEAT0_IDX = 8'h3A;
    localparam logic [7:0] FEAT1_IDX = 8'h3B;
    localparam logic [7:0] FEAT2_IDX = 8'h3C;
    localparam logic [7:0] FEAT3_IDX = 8'h3D;
    localparam logic [7:0] SUSP_IDX = 8'h3E;
    localparam logic [7:0] LOCK0_IDX = 8'h3F;
    localparam logic [7:0] LOCK1_IDX = 8'h40;

    // table contents
    localparam logic [15:0] PTR_VAL = 16'h0035;
    localparam logic [7:0] SIG0_VAL = 8'h50;
    localparam logic [7:0] SIG1_VAL = 8'h52;
    localparam logic [7:0] SIG2_VAL = 8'h49;
    localparam logic [7:0] MAJOR_VAL = 8'h31;
    localparam logic [7:0] MINOR_VAL = 8'h30;
    localparam logic [31:0] FEAT_VAL = 32'h00000006;
    localparam logic [7:0] SUSP_VAL = 8'h01;
    localparam logic [15:0] LOCK_VAL = 16'h0003;

    // bus map
    localparam logic [11:0] CTRL_ADDR = 12'h400;
    localparam logic [11:0] STAT_ADDR = 12'h404;
    localparam logic [1:0] QUERY_AREA = 2'h0;

    // control fields
    localparam int CTRL_QEN_BIT = 0;
    localparam int CTRL_ESUSP_BIT = 1;
    localparam int CTRL_PSUSP_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;

    // status fields
    localparam int STAT_OFS_LSB = 0;
    localparam int STAT_QEN_BIT = 8;
    localparam int STAT_SUSP_LSB = 9;
    localparam int STAT_CNT_LSB = 16;

    // responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_ROM = 2'b01,
        RD_RESP = 2'b11
    } rd_state_t;

    typedef enum logic [1:0] {
        KIND_QUERY = 2'h0,
        KIND_CTRL = 2'h1,
        KIND_STAT = 2'h2,
        KIND_NONE = 2'h3
    } kind_t;

endpackage

// [rtl/query_rom.sv]
// Purpose: fixed query byte table with registered read data
// Assumes: one lookup per enable, data valid the cycle after
// Notes: hit_r low for locations this table does not hold
`timescale 1ns/100ps
module query_rom (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rd_en,
    input wire logic [7:0] rd_idx,
    output logic [7:0] rd_byte_r,
    output logic rd_hit_r
);
    logic [7:0] byte_nxt;
    logic hit_nxt;

    // multi-byte fields: least significant byte at lowest location [RULE11]
    always_comb begin
        byte_nxt = 8'h00;
        hit_nxt = 1'b1;
        case (rd_idx)
            ext_query_pkg::PTR_LO_IDX: byte_nxt = ext_query_pkg::PTR_VAL[7:0]; // [RULE9] [RULE10]
            ext_query_pkg::PTR_HI_IDX: byte_nxt = ext_query_pkg::PTR_VAL[15:8]; // [RULE10]
            ext_query_pkg::SIG0_IDX: byte_nxt = ext_query_pkg::SIG0_VAL; // [RULE1]
            ext_query_pkg::SIG1_IDX: byte_nxt = ext_query_pkg::SIG1_VAL; // [RULE1]
            ext_query_pkg::SIG2_IDX: byte_nxt = ext_query_pkg::SIG2_VAL; // [RULE1]
            ext_query_pkg::MAJOR_IDX: byte_nxt = ext_query_pkg::MAJOR_VAL; // [RULE2]
            ext_query_pkg::MINOR_IDX: byte_nxt = ext_query_pkg::MINOR_VAL; // [RULE3]
            ext_query_pkg::FEAT0_IDX: byte_nxt = ext_query_pkg::FEAT_VAL[7:0]; // [RULE4]
            ext_query_pkg::FEAT1_IDX: byte_nxt = ext_query_pkg::FEAT_VAL[15:8]; // [RULE5]
            ext_query_pkg::FEAT2_IDX: byte_nxt = ext_query_pkg::FEAT_VAL[23:16]; // [RULE5]
            ext_query_pkg::FEAT3_IDX: byte_nxt = ext_query_pkg::FEAT_VAL[31:24]; // [RULE5]
            ext_query_pkg::SUSP_IDX: byte_nxt = ext_query_pkg::SUSP_VAL; // [RULE7]
            ext_query_pkg::LOCK0_IDX: byte_nxt = ext_query_pkg::LOCK_VAL[7:0]; // [RULE8]
            ext_query_pkg::LOCK1_IDX: byte_nxt = ext_query_pkg::LOCK_VAL[15:8]; // [RULE8]
            default: hit_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_byte_r <= 8'h00;
            rd_hit_r <= 1'b0;
        end else if (rd_en) begin
            rd_byte_r <= byte_nxt;
            rd_hit_r <= hit_nxt;
        end
    end
endmodule

// [rtl/ext_query_responder.sv]
// Purpose: AXI4-Lite responder for the extended query table
// Assumes: one read and one write at most under way at a time
// Notes: only the low 12 address bits are decoded; upper bits alias
//
// Function
// (RULE1) signature locations read 50, 52, 49
// (RULE2) major version location reads 31
// (RULE3) minor version location reads 30
// (RULE4) first feature byte reads 06, one flag per feature
// (RULE5) reserved feature bits 5 to 31 read zero
// (RULE6) query reads are accepted while erase or program is suspended
// (RULE7) functions-after-suspend byte reads 01, upper bits zero
// (RULE8) lock status field reads 03 then 00
// (RULE9) table base comes from pointer at location 15; host reads it first
// (RULE10) pointer reads 35 low byte, 00 high byte
// (RULE11) least significant byte at lowest location, one byte on low lines
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ext_query_responder #(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    generate
        if (ADDR_W < 12) begin : g_bad_addr
            $error("ADDR_W must be at least 12");
        end
    endgenerate

    ext_query_pkg::rd_state_t rd_state_r;
    ext_query_pkg::kind_t rd_kind_r;
    ext_query_pkg::kind_t ar_kind;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] rd_idx_r;
    logic [31:0] rd_word_nxt;
    logic [1:0] rd_resp_nxt;
    logic rom_en;
    logic [7:0] rom_byte;
    logic rom_hit;
    logic q_sel;

    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic aw_got_r;
    logic w_got_r;
    logic [11:0] wr_addr_r;
    logic [2:0] wr_data_r;
    logic wr_lane0_r;

    logic [2:0] ctrl_r;
    logic [7:0] last_ofs_r;
    logic [15:0] qcnt_r;
    logic [31:0] stat_word;

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // read address decode
    always_comb begin
        if (araddr[11:10] == ext_query_pkg::QUERY_AREA) begin
            ar_kind = ext_query_pkg::KIND_QUERY;
        end else if (araddr[11:0] == ext_query_pkg::CTRL_ADDR) begin
            ar_kind = ext_query_pkg::KIND_CTRL;
        end else if (araddr[11:0] == ext_query_pkg::STAT_ADDR) begin
            ar_kind = ext_query_pkg::KIND_STAT;
        end else begin
            ar_kind = ext_query_pkg::KIND_NONE;
        end
    end

    assign rom_en = arvalid && arready_r;

    query_rom u_rom (
        .aclk(aclk),
        .aresetn(aresetn),
        .rd_en(rom_en),
        .rd_idx(araddr[9:2]),
        .rd_byte_r(rom_byte),
        .rd_hit_r(rom_hit)
    );

    assign q_sel = (rd_kind_r == ext_query_pkg::KIND_QUERY) && ctrl_r[ext_query_pkg::CTRL_QEN_BIT];

    // status word assembly
    always_comb begin
        stat_word = 32'h00000000;
        stat_word[ext_query_pkg::STAT_OFS_LSB +: 8] = last_ofs_r;
        stat_word[ext_query_pkg::STAT_QEN_BIT] = ctrl_r[ext_query_pkg::CTRL_QEN_BIT];
        stat_word[ext_query_pkg::STAT_SUSP_LSB +: 2] = ctrl_r[2:1];
        stat_word[ext_query_pkg::STAT_CNT_LSB +: 16] = qcnt_r;
    end

    // read data selection; query bytes sit on the low lines [RULE11]
    always_comb begin
        rd_word_nxt = 32'h00000000;
        rd_resp_nxt = ext_query_pkg::RESP_OKAY;
        case (rd_kind_r)
            ext_query_pkg::KIND_QUERY: begin
                if (!ctrl_r[ext_query_pkg::CTRL_QEN_BIT]) begin
                    rd_word_nxt = 32'h00000000;
                end else if (rom_hit) begin
                    rd_word_nxt = {24'h000000, rom_byte}; // [RULE11]
                end else begin
                    rd_resp_nxt = ext_query_pkg::RESP_DECERR;
                end
            end
            ext_query_pkg::KIND_CTRL: rd_word_nxt = {29'h00000000, ctrl_r};
            ext_query_pkg::KIND_STAT: rd_word_nxt = stat_word;
            default: rd_resp_nxt = ext_query_pkg::RESP_DECERR;
        endcase
    end

    // read channel; never gated by suspend state [RULE6]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= ext_query_pkg::RD_IDLE;
            rd_kind_r <= ext_query_pkg::KIND_NONE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= ext_query_pkg::RESP_OKAY;
            rd_idx_r <= 8'h00;
        end else begin
            case (rd_state_r)
                ext_query_pkg::RD_IDLE: begin
                    arready_r <= 1'b1;
                    if (arvalid && arready_r) begin // [RULE6]
                        arready_r <= 1'b0;
                        rd_idx_r <= araddr[9:2];
                        rd_kind_r <= ar_kind;
                        rd_state_r <= ext_query_pkg::RD_ROM;
                    end
                end
                ext_query_pkg::RD_ROM: begin
                    rvalid_r <= 1'b1;
                    rdata_r <= rd_word_nxt;
                    rresp_r <= rd_resp_nxt;
                    rd_state_r <= ext_query_pkg::RD_RESP;
                end
                ext_query_pkg::RD_RESP: begin
                    if (rready) begin
                        rvalid_r <= 1'b0;
                        rd_state_r <= ext_query_pkg::RD_IDLE;
                    end
                end
                default: begin
                    arready_r <= 1'b0;
                    rvalid_r <= 1'b0;
                    rd_state_r <= ext_query_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // query read bookkeeping for the status word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_ofs_r <= 8'h00;
            qcnt_r <= 16'h0000;
        end else if (rd_state_r == ext_query_pkg::RD_ROM && q_sel && rom_hit) begin
            last_ofs_r <= rd_idx_r;
            qcnt_r <= qcnt_r + 16'h0001;
        end
    end

    // write channel; address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= ext_query_pkg::RESP_OKAY;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            wr_addr_r <= 12'h000;
            wr_data_r <= 3'h0;
            wr_lane0_r <= 1'b0;
            ctrl_r <= ext_query_pkg::CTRL_RESET;
        end else begin
            awready_r <= !aw_got_r && !bvalid_r && !(awvalid && awready_r);
            wready_r <= !w_got_r && !bvalid_r && !(wvalid && wready_r);
            if (awvalid && awready_r) begin
                aw_got_r <= 1'b1;
                wr_addr_r <= awaddr[11:0];
            end
            if (wvalid && wready_r) begin
                w_got_r <= 1'b1;
                wr_data_r <= wdata[2:0];
                wr_lane0_r <= wstrb[0];
            end
            if (aw_got_r && w_got_r && !bvalid_r) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                if (wr_addr_r == ext_query_pkg::CTRL_ADDR) begin
                    bresp_r <= ext_query_pkg::RESP_OKAY;
                    if (wr_lane0_r) begin
                        ctrl_r <= wr_data_r;
                    end
                end else if (wr_addr_r[11:10] == ext_query_pkg::QUERY_AREA ||
                             wr_addr_r == ext_query_pkg::STAT_ADDR) begin
                    bresp_r <= ext_query_pkg::RESP_SLVERR;
                end else begin
                    bresp_r <= ext_query_pkg::RESP_DECERR;
                end
            end
            if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // checks on the answers the table gives
    property p_sig;
        @(posedge aclk) disable iff (!aresetn)
        (rd_state_r == ext_query_pkg::RD_ROM && q_sel && rd_idx_r == 8'h35) |=>
            (rvalid_r && rdata_r == 32'h00000050);
    endproperty
    a_sig: assert property (p_sig) else $error("signature byte 0 wrong"); // [RULE1]

    property p_sig_tail;
        @(posedge aclk) disable iff (!aresetn)
        (rd_state_r == ext_query_pkg::RD_ROM && q_sel && rd_idx_r inside {8'h36, 8'h37}) |=>
            rdata_r[7:0] == (rd_idx_r == 8'h36 ? 8'h52 : 8'h49);
    endproperty
    a_sig_tail: assert property (p_sig_tail) else $error("signature tail wrong"); // [RULE1]

    property p_major;
        @(posedge aclk) disable iff (!aresetn)
        $rose(rvalid_r) && q_sel && rd_idx_r == 8'h38 |-> rdata_r[7:0] == 8'h31;
    endproperty
    a_major: assert property (p_major) else $error("major version wrong"); // [RULE2]

    property p_minor;
        @(posedge aclk) disable iff (!aresetn)
        $rose(rvalid_r) && q_sel && rd_idx_r == 8'h39 |-> rdata_r[7:0] == 8'h30;
    endproperty
    a_minor: assert property (p_minor) else $error("minor version wrong"); // [RULE3]

    property p_feat;
        @(posedge aclk) disable iff (!aresetn)
        (rd_state_r == ext_query_pkg::RD_ROM && q_sel && rd_idx_r == 8'h3A) |=>
            (rdata_r[7:0] == 8'h06 && rresp_r == 2'h0);
    endproperty
    a_feat: assert property (p_feat) else $error("feature byte wrong"); // [RULE4]

    property p_feat_rsvd;
        @(posedge aclk) disable iff (!aresetn)
        (rd_state_r == ext_query_pkg::RD_ROM && q_sel && rd_idx_r inside {[8'h3B:8'h3D]}) |=>
            (rvalid_r && rdata_r == 32'h00000000);
    endproperty
    a_feat_rsvd: assert property (p_feat_rsvd) else $error("reserved feature bits set"); // [RULE5]

    property p_susp_read;
        @(posedge aclk) disable iff (!aresetn)
        (arvalid && arready_r && ctrl_r[2:1] != 2'b00) |->
            ##2 (rvalid_r && rresp_r != 2'h2);
    endproperty
    a_susp_read: assert property (p_susp_read) else $error("read refused while suspended"); // [RULE6]

    property p_after_susp;
        @(posedge aclk) disable iff (!aresetn)
        $rose(rvalid_r) && q_sel && rd_idx_r == 8'h3E |-> rdata_r == 32'h00000001;
    endproperty
    a_after_susp: assert property (p_after_susp) else $error("suspend field wrong"); // [RULE7]

    property p_lock;
        @(posedge aclk) disable iff (!aresetn)
        (rd_state_r == ext_query_pkg::RD_ROM && q_sel && rd_idx_r inside {8'h3F, 8'h40}) |=>
            rdata_r[7:0] == (rd_idx_r == 8'h3F ? 8'h03 : 8'h00);
    endproperty
    a_lock: assert property (p_lock) else $error("lock status field wrong"); // [RULE8]

    property p_ptr;
        @(posedge aclk) disable iff (!aresetn)
        $rose(rvalid_r) && q_sel && rd_idx_r inside {8'h15, 8'h16} |->
            rdata_r[7:0] == (rd_idx_r == 8'h15 ? 8'h35 : 8'h00) && rresp_r == 2'h0;
    endproperty
    a_ptr: assert property (p_ptr) else $error("table pointer wrong"); // [RULE9] [RULE10]

    property p_low_lines;
        @(posedge aclk) disable iff (!aresetn)
        (rvalid_r && rd_kind_r == ext_query_pkg::KIND_QUERY) |-> rdata_r[31:8] == 24'h000000;
    endproperty
    a_low_lines: assert property (p_low_lines) else $error("query data above low byte"); // [RULE11]

endmodule

// [sim/axil_host.sv]
// Purpose: bus master model that issues query and register accesses
// Assumes: tasks are entered just after a rising edge of aclk
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/100ps
module axil_host (
    input wire logic aclk,
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        awaddr = 12'h000;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 12'h000;
        arvalid = 1'b0;
        rready = 1'b0;
    end

    // one read; st idle cycles before the response is accepted
    task automatic rd(input logic [11:0] a, input int st, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~a;
        repeat (st) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // one write; address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                      input int st, output logic [1:0] r);
        bit ad;
        bit wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= s;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~v;
            end
        end while (!(ad && wd));
        repeat (st) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
endmodule

// [sim/tb_extended_query_table_responder.sv]
// Purpose: self-checking bench for the extended query table responder
// Assumes: query location n at byte address 4*n, control at 0x400
// Notes: random addresses and response stalls from a fixed xorshift seed
`timescale 1ns/100ps
module tb_extended_query_table_responder;
    localparam logic [11:0] CTRL = 12'h400;
    localparam logic [7:0] P_EXP = 8'h35;
    localparam logic [7:0] EXT [12] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h06,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00};
    localparam logic [2:0] MODES [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
    logic aclk;
    logic aresetn;
    logic [11:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] seed = 32'h1D74;
    int err_total = 0;
    int check_count = 0;

    ext_query_responder #(.ADDR_W(12)) dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    axil_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected {hit, byte} of a query location
    function automatic logic [8:0] exp_loc(input logic [7:0] i);
        if (i == 8'h15) return 9'h135;
        if (i == 8'h16) return 9'h100;
        if (i >= P_EXP && i < P_EXP + 8'h0C) return {1'b1, EXT[i - P_EXP]};
        return 9'h000;
    endfunction

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t data got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask

    task end_of_test();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] p;
        logic [7:0] i;
        logic [8:0] e;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // table base taken from the pointer before any table access
        host.rd(12'h054, 0, d, r);
        chk_data(d, 32'h00000035);
        p = d[7:0];
        host.rd(12'h058, 3, d, r);
        chk_data(d, 32'h00000000);
        // whole table under every suspend combination
        foreach (MODES[m]) begin
            host.wr(CTRL, {29'h0, MODES[m]}, 4'hF, int'(rnd() % 4), r);
            chk_resp(r, 2'h0);
            for (int k = 0; k < 12; k++) begin
                host.rd({2'b00, p + 8'(k), 2'b00}, int'(rnd() % 4), d, r);
                chk_data(d, {24'h0, EXT[k]});
                chk_resp(r, 2'h0);
            end
        end
        host.rd(12'h404, 1, d, r);
        chk_data(d, 32'h00320740);
        // query mode off, then a refused write into the table
        host.wr(CTRL, 32'h00000000, 4'hF, 0, r);
        host.rd(12'h0D4, 0, d, r);
        chk_data(d, 32'h00000000);
        chk_resp(r, 2'h0);
        host.wr(CTRL, 32'h00000001, 4'hF, 2, r);
        host.wr(12'h0D4, rnd(), 4'hF, 1, r);
        chk_resp(r, 2'h2);
        host.rd(12'h0D4, 0, d, r);
        chk_data(d, 32'h00000050);
        host.rd(12'h800, 0, d, r);
        chk_resp(r, 2'h3);
        // write to an unmapped word, then a control write without lane 0
        host.wr(12'h800, rnd(), 4'hF, 0, r);
        chk_resp(r, 2'h3);
        host.wr(CTRL, 32'h00000006, 4'hE, 1, r);
        chk_resp(r, 2'h0);
        host.rd(CTRL, 0, d, r);
        chk_data(d, 32'h00000001);
        // random locations 0 to 79, across the table and beyond its end
        repeat (200) begin
            i = 8'(rnd() % 80);
            e = exp_loc(i);
            host.rd({2'b00, i, 2'b00}, int'(rnd() % 3), d, r);
            chk_data(d, {24'h0, e[7:0]});
            chk_resp(r, e[8] ? 2'h0 : 2'h3);
        end
        // second reset in mid-run restores query mode
        host.wr(CTRL, 32'h00000000, 4'hF, 0, r);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        host.rd(CTRL, 0, d, r);
        chk_data(d, 32'h00000001);
        host.rd(12'h0DC, 0, d, r);
        chk_data(d, 32'h00000049);
        end_of_test();
    end
endmodule
